/* bench/pwm_seq_properties.sv */
`timescale 1ns/1ps
module pwm_seq_properties (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic period_end,
	input wire logic ram_ack,
	input wire logic ram_req,
	input wire logic [31:0] ram_addr,
	input pwm_seq_pkg::sample_type compare_value,
	input wire logic compare_load,
	input wire logic [pwm_seq_pkg::TOP_W-1:0] counter_top,
	input wire logic gen_running
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// a word counts as taken on the edge where the answer is high
	sequence s_word_taken;
		ram_req && ram_ack;
	endsequence
	sequence s_next_word;
		s_word_taken ##1 ram_req;
	endsequence
	AST_READ_QUIET: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside the answer cycle");
	AST_RAM_HOLD: assert property (ram_req && !ram_ack |=> ram_req && $stable(ram_addr))
		else $error("fetch request dropped or moved before its answer");
	AST_RAM_STEP: assert property (s_next_word |-> ram_addr == $past(ram_addr) + 32'h2)
		else $error("fetch address did not step by one halfword");
	AST_CMP_ON_LOAD: assert property ($changed(compare_value) |-> compare_load)
		else $error("compare value changed without a load");
	AST_LOAD_AT_END: assert property ($past(gen_running) && compare_load |-> $past(period_end))
		else $error("sample applied away from a period end");
	AST_TOP_AT_END: assert property ($past(gen_running) && $changed(counter_top) |-> $past(period_end))
		else $error("counter top changed inside a period");
	AST_LOAD_PULSE: assert property (compare_load |=> !compare_load)
		else $error("load pulse longer than one cycle");
	AST_START_LOAD: assert property ($rose(gen_running) |-> compare_load)
		else $error("generation started without a sample");
	AST_STOP_AT_END: assert property ($fell(gen_running) |-> $past(period_end))
		else $error("generation stopped inside a period");
endmodule
bind pwm_sequence_playback_control pwm_seq_properties chk (.ref_clk, .sys_rst, .reg_read,
	.reg_rdata, .period_end, .ram_ack, .ram_req, .ram_addr, .compare_value, .compare_load,
	.counter_top, .gen_running);

/* bench/ram_model.sv */
`timescale 1ns/1ps
module ram_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] latency,
	input wire logic ram_req,
	input wire logic [31:0] ram_addr,
	output logic ram_ack,
	output logic [pwm_seq_pkg::CMP_W-1:0] ram_rdata
);
	logic [7:0] wait_cnt;
	// answer each word after latency cycles; idle data toggles so stale reads show
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ram_ack <= 1'b0;
			wait_cnt <= 8'h00;
			ram_rdata <= 16'h0000;
		end else if (!ram_ack && ram_req && wait_cnt >= latency) begin
			ram_ack <= 1'b1;
			ram_rdata <= ram_addr[15:0] ^ 16'hc3a5;
		end else begin
			ram_ack <= 1'b0;
			wait_cnt <= (ram_req && !ram_ack) ? wait_cnt + 8'h01 : 8'h00;
			ram_rdata <= ~ram_rdata;
		end
	end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
	typedef struct {
		pwm_seq_pkg::sample_type v;
		logic [14:0] top;
		int per;
	} note_type;
	logic ref_clk, sys_rst, clk_en, reg_write, reg_read, period_end, rd_due;
	logic ram_ack, ram_req, compare_load, gen_running, irq;
	logic [7:0] reg_addr, latency;
	logic [31:0] reg_wdata, reg_rdata, ram_addr, ptr;
	logic [15:0] ram_rdata;
	logic [14:0] counter_top, wrap;
	logic [4:0] pcnt;
	pwm_seq_pkg::sample_type compare_value;
	note_type sq[$];
	note_type got;
	logic [31:0] rq[$];
	int seed, bad_count, compares, np, nw;

	pwm_sequence_playback_control dut (.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .period_end, .ram_ack, .ram_rdata, .ram_req,
		.ram_addr, .compare_value, .compare_load, .counter_top, .gen_running, .irq);
	ram_model ram (.ref_clk, .sys_rst, .latency, .ram_req, .ram_addr, .ram_ack, .ram_rdata);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// wave counter stand-in: one period end every 32 cycles
	always @(posedge ref_clk) begin
		pcnt <= pcnt + 5'h01;
		period_end <= (pcnt == 5'h1f);
	end

	// read answers and applied samples are matched against the oldest note
	always @(posedge ref_clk) begin
		rd_due <= reg_read;
		if (rd_due) chk("rdata", reg_rdata, rq.pop_front());
		if (compare_load) begin
			if (sq.size() == 0) chk("extra load", 1, 0);
			else begin
				got = sq.pop_front();
				chk("compare", compare_value, got.v);
				chk("top", counter_top, got.top);
				if (got.per >= 0) chk("periods", np, got.per);
			end
			np = 0;
		end
		if (period_end) np++;
	end

	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e);
		rq.push_back(e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
	endtask

	task automatic setseq(int s, logic [31:0] p, int cnt, int rf, int gp);
		logic [7:0] b;
		b = 8'(pwm_seq_pkg::OFS_SEQ_BASE + s * pwm_seq_pkg::OFS_SEQ_STRIDE);
		wr(b, p);
		wr(b + 8'h04, 32'(cnt));
		wr(b + 8'h08, 32'(rf));
		wr(b + 8'h0c, 32'(gp));
	endtask

	// what 0: all samples seen, 1: running, 2: stopped
	task automatic till(int what);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(posedge ref_clk);
			if (what == 0 && sq.size() == 0 || what == 1 && gen_running === 1'b1) break;
			if (what == 2 && gen_running === 1'b0) break;
		end
		if (i == 3000) begin
			chk("timeout", 1, 0);
			stop_test();
		end
	endtask

	// sample k of a sequence at p, routed as the load mode says
	function automatic note_type mk(int m, logic [31:0] p, int k, int per, logic [14:0] top);
		logic [15:0] w [4];
		note_type n;
		int words;
		words = (m == 0) ? 1 : (m == 1) ? 2 : 4;
		for (int j = 0; j < 4; j++) w[j] = 16'(p + 32'(2 * (k * words + j))) ^ 16'hc3a5;
		n.per = per;
		n.top = top;
		case (m)
			0: n.v = {4{w[0]}};
			1: n.v = {w[1], w[1], w[0], w[0]};
			2: n.v = {w[3], w[2], w[1], w[0]};
			default: begin
				n.v = {16'h0000, w[2], w[1], w[0]};
				n.top = w[3][14:0];
			end
		endcase
		return n;
	endfunction

	task automatic halt();
		wr(pwm_seq_pkg::OFS_TASK, 32'h8);
		till(2);
		wr(pwm_seq_pkg::OFS_STATUS, 32'h7f);
	endtask

	task automatic stop_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		seed = 44;
		{sys_rst, clk_en, reg_write, reg_read, rd_due, period_end} = 6'h30;
		{reg_addr, reg_wdata, pcnt, np} = '0;
		latency = 8'h02;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(pwm_seq_pkg::OFS_MASK, 32'h0);
		// a write while the enable is low must leave no trace
		clk_en <= 1'b0;
		wr(pwm_seq_pkg::OFS_MASK, 32'h7f);
		clk_en <= 1'b1;
		rd(pwm_seq_pkg::OFS_MASK, 32'h0);
		wr(8'hfc, 32'hffffffff);
		rd(8'hfc, 32'h0);
		// every load mode, one sequence played once, top rewritten mid-run
		// pin routing lives outside; pointer and wrap of seq 0 are rewritten once running
		for (int m = 0; m < 4; m++) begin
			latency <= 8'({$random(seed)} % 4) + 8'h01;
			wrap = 15'($random(seed)) | 15'h0100;
			ptr = {$random(seed)} & 32'h0000fffe;
			nw = (m == 0) ? 1 : (m == 1) ? 2 : 4;
			wr(pwm_seq_pkg::OFS_CONFIG, 32'(m));
			wr(pwm_seq_pkg::OFS_WRAP, 32'(wrap));
			setseq(0, ptr, 2 * nw, 1, 0);
			sq.push_back(mk(m, ptr, 0, -1, wrap));
			sq.push_back(mk(m, ptr, 1, 2, wrap ^ 15'h0001));
			wr(pwm_seq_pkg::OFS_TASK, 32'h1);
			till(1);
			wr(8'(pwm_seq_pkg::OFS_SEQ_BASE), ~ptr);
			wr(pwm_seq_pkg::OFS_WRAP, 32'(wrap ^ 15'h0001));
			till(0);
			repeat (100) @(posedge ref_clk);
			rd(pwm_seq_pkg::OFS_STATUS, 32'h2a);
			halt();
		end
		// chained playback, one pass of seq 0 then seq 1
		wr(pwm_seq_pkg::OFS_CONFIG, 32'h0);
		wr(pwm_seq_pkg::OFS_WRAP, 32'(wrap));
		wr(pwm_seq_pkg::OFS_CHAIN, 32'h1);
		setseq(0, 32'h1000, 2, 1, 1);
		setseq(1, 32'h2000, 2, 0, 0);
		sq.push_back(mk(0, 32'h1000, 0, -1, wrap));
		sq.push_back(mk(0, 32'h1000, 1, 2, wrap));
		sq.push_back(mk(0, 32'h2000, 0, 3, wrap));
		sq.push_back(mk(0, 32'h2000, 1, 1, wrap));
		wr(pwm_seq_pkg::OFS_TASK, 32'h1);
		till(0);
		repeat (100) @(posedge ref_clk);
		rd(pwm_seq_pkg::OFS_STATUS, 32'h7e);
		// interrupt raised, masked off, then cleared
		wr(pwm_seq_pkg::OFS_MASK, 32'h40);
		repeat (3) @(posedge ref_clk);
		chk("irq", irq, 1'b1);
		wr(pwm_seq_pkg::OFS_MASK, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk("irq", irq, 1'b0);
		wr(pwm_seq_pkg::OFS_MASK, 32'h40);
		wr(pwm_seq_pkg::OFS_STATUS, 32'h40);
		repeat (3) @(posedge ref_clk);
		chk("irq", irq, 1'b0);
		halt();
		// step on command: timing registers ignored, one sample per advance
		wr(pwm_seq_pkg::OFS_CHAIN, 32'h0);
		wr(pwm_seq_pkg::OFS_CONFIG, 32'h4);
		setseq(1, 32'h3000, 3, 5, 5);
		for (int k = 0; k < 3; k++) sq.push_back(mk(0, 32'h3000, k, -1, wrap));
		wr(pwm_seq_pkg::OFS_TASK, 32'h2);
		till(1);
		repeat (200) @(posedge ref_clk);
		chk("pending", sq.size(), 2);
		for (int i = 1; i >= 0; i--) begin
			wr(pwm_seq_pkg::OFS_TASK, 32'h4);
			repeat (70) @(posedge ref_clk);
			chk("pending", sq.size(), i);
		end
		halt();
		// memory slower than a period: old value stays until the fetch lands
		latency <= 8'h1e;
		wr(pwm_seq_pkg::OFS_CONFIG, 32'h2);
		setseq(0, 32'h4000, 8, 0, 0);
		sq.push_back(mk(2, 32'h4000, 0, -1, wrap));
		sq.push_back(mk(2, 32'h4000, 1, -1, wrap));
		wr(pwm_seq_pkg::OFS_TASK, 32'h1);
		till(0);
		halt();
		stop_test();
	end
endmodule

/* logic/pwm_seq_pkg.sv */
package pwm_seq_pkg;

	// register byte addresses on the plain register port
	localparam logic [7:0] OFS_TASK = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_CONFIG = 8'h0c;
	localparam logic [7:0] OFS_CHAIN = 8'h10;
	localparam logic [7:0] OFS_WRAP = 8'h14;
	localparam logic [7:0] OFS_STATE = 8'h18;
	localparam int OFS_SEQ_BASE = 'h20;
	localparam int OFS_SEQ_STRIDE = 'h10;
	localparam int REG_BYTES = 4;

	// per-sequence register slots
	localparam int SEQ_F_PTR = 0;
	localparam int SEQ_F_COUNT = 1;
	localparam int SEQ_F_REFRESH = 2;
	localparam int SEQ_F_GAP = 3;

	// task register bits
	localparam int TASK_LAUNCH0 = 0;
	localparam int TASK_LAUNCH1 = 1;
	localparam int TASK_ADVANCE = 2;
	localparam int TASK_STOP = 3;

	// event bits, shared by status and mask
	localparam int EV_STOPPED = 0;
	localparam int EV_BEGUN0 = 1;
	localparam int EV_FINISHED0 = 3;
	localparam int EV_PERIOD = 5;
	localparam int EV_CHAIN_DONE = 6;
	localparam int EV_W = 7;

	// configuration register fields
	localparam int CFG_LOAD_LSB = 0;
	localparam int CFG_STEP_BIT = 2;

	// widths
	localparam int CNT_W = 15;
	localparam int REFRESH_W = 24;
	localparam int LOOP_W = 16;
	localparam int CMP_W = 16;
	localparam int TOP_W = 15;
	localparam int SAMPLE_WORDS = 4;
	localparam logic [2:0] WORDS_COMMON = 3'h1;
	localparam logic [2:0] WORDS_GROUPED = 3'h2;
	localparam logic [2:0] WORDS_FULL = 3'h4;
	localparam logic [31:0] HALFWORD_BYTES = 32'h2;

	typedef enum logic [1:0] {
		LOAD_COMMON,
		LOAD_GROUPED,
		LOAD_INDIVIDUAL,
		PERIOD_PER_SAMPLE_LOAD_MODE
	} load_mode_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_PLAY,
		ST_GAP,
		ST_FINAL
	} play_state_type;

	typedef logic [SAMPLE_WORDS-1:0][CMP_W-1:0] sample_type;

	typedef struct packed {
		logic [31:0] ptr;
		logic [CNT_W-1:0] count;
		logic [REFRESH_W-1:0] refresh;
		logic [REFRESH_W-1:0] gap;
	} seq_cfg_type;

	typedef struct packed {
		logic go;
		logic [31:0] addr;
		logic [2:0] words;
	} fetch_req_type;

endpackage

/* logic/pwm_sequence_playback_control.sv */
// How it works
// RULE_01: start pointer and count captured at launch
// RULE_02: software rewrites pointer/count after begun event
// RULE_03: refresh and gap resampled at launch, apply
// RULE_04: period_per_sample_load_mode load ignores wrap register, uses word
// RULE_05: other loads take wrap value at period end
// RULE_06: mode, decoder, loop registers act immediately
// RULE_07: software sets pin selection before enabling
// RULE_08: after chain done, hold last value indefinitely
// RULE_09: chain plays seq 0, gap, seq 1, gap
// RULE_10: chain always finishes after sequence 1 pass
// RULE_11: each sample held refresh plus one periods
// RULE_12: gap inserts whole periods between sequences
// RULE_13: repeat chain count times, two events end
// RULE_14: advance task loads next sample next period
// RULE_15: software keeps every sample count nonzero
// RULE_16: slow fetch repeats previous compare value
// RULE_17: step mode ignores refresh and gap
// RULE_18: zero repeat count plays once, holds last
// RULE_19: chain passes counted, cleared at each launch
`timescale 1ns/1ps
module pwm_sequence_playback_control (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic period_end,
	input wire logic ram_ack,
	input wire logic [pwm_seq_pkg::CMP_W-1:0] ram_rdata,
	output logic ram_req,
	output logic [31:0] ram_addr,
	output pwm_seq_pkg::sample_type compare_value,
	output logic compare_load,
	output logic [pwm_seq_pkg::TOP_W-1:0] counter_top,
	output logic gen_running,
	output logic irq
);
	// software registers
	pwm_seq_pkg::seq_cfg_type seq_cfg [2];
	pwm_seq_pkg::load_mode_type load_mode;
	logic step_on_command_mode;
	logic [pwm_seq_pkg::LOOP_W-1:0] chain_repeat_count;
	logic [pwm_seq_pkg::TOP_W-1:0] counter_wrap_value;
	logic [pwm_seq_pkg::EV_W-1:0] status;
	logic [pwm_seq_pkg::EV_W-1:0] mask;

	// playback state
	pwm_seq_pkg::play_state_type state;
	pwm_seq_pkg::seq_cfg_type cur;
	pwm_seq_pkg::fetch_req_type fetch_req;
	pwm_seq_pkg::sample_type fetch_sample;
	logic fetch_done;
	logic seq_sel;
	logic [pwm_seq_pkg::CNT_W-1:0] idx;
	logic [pwm_seq_pkg::LOOP_W-1:0] iter;
	logic [pwm_seq_pkg::REFRESH_W-1:0] hold_cnt;
	logic [pwm_seq_pkg::REFRESH_W:0] gap_cnt;
	logic buf_ready;
	logic fetch_last;
	logic play_last;
	logic stop_pending;
	logic step_pending;
	logic [pwm_seq_pkg::EV_W-1:0] ev;

	// decoded strobes and decisions
	logic task_wr;
	logic [1:0] launch;
	logic task_adv;
	logic task_stop;
	logic do_launch;
	logic do_switch;
	logic do_apply;
	logic do_stop;
	logic play_expire;
	logic hold_done;
	logic target;
	logic [2:0] wps;
	logic [pwm_seq_pkg::CNT_W-1:0] idx_next;

	function automatic logic seq_field_hit(input logic [7:0] addr, input int n, input int f);
		seq_field_hit = addr == 8'(pwm_seq_pkg::OFS_SEQ_BASE + n * pwm_seq_pkg::OFS_SEQ_STRIDE
			+ f * pwm_seq_pkg::REG_BYTES);
	endfunction

	function automatic logic [2:0] words_per(input pwm_seq_pkg::load_mode_type m);
		unique case (m)
			pwm_seq_pkg::LOAD_COMMON: words_per = pwm_seq_pkg::WORDS_COMMON;
			pwm_seq_pkg::LOAD_GROUPED: words_per = pwm_seq_pkg::WORDS_GROUPED;
			pwm_seq_pkg::LOAD_INDIVIDUAL: words_per = pwm_seq_pkg::WORDS_FULL;
			pwm_seq_pkg::PERIOD_PER_SAMPLE_LOAD_MODE: words_per = pwm_seq_pkg::WORDS_FULL;
		endcase
	endfunction

	// route fetched halfwords to the four compare channels
	function automatic pwm_seq_pkg::sample_type route(input pwm_seq_pkg::sample_type s,
		input pwm_seq_pkg::load_mode_type m);
		route = s;
		unique case (m)
			pwm_seq_pkg::LOAD_COMMON: route = {s[0], s[0], s[0], s[0]};
			pwm_seq_pkg::LOAD_GROUPED: route = {s[1], s[1], s[0], s[0]};
			pwm_seq_pkg::LOAD_INDIVIDUAL: route = s;
			pwm_seq_pkg::PERIOD_PER_SAMPLE_LOAD_MODE: route = {16'h0000, s[2], s[1], s[0]};
		endcase
	endfunction

	sample_fetch fetcher (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.req(fetch_req),
		.ram_ack(ram_ack),
		.ram_rdata(ram_rdata),
		.ram_req(ram_req),
		.ram_addr(ram_addr),
		.sample(fetch_sample),
		.done(fetch_done)
	);

	// task strobes and the playback decisions of this cycle
	always_comb begin
		task_wr = reg_write && reg_addr == pwm_seq_pkg::OFS_TASK;
		launch = task_wr ? reg_wdata[pwm_seq_pkg::TASK_LAUNCH1:pwm_seq_pkg::TASK_LAUNCH0] : 2'h0;
		task_adv = task_wr && reg_wdata[pwm_seq_pkg::TASK_ADVANCE];
		task_stop = task_wr && reg_wdata[pwm_seq_pkg::TASK_STOP];
		wps = words_per(load_mode); // see RULE_06
		idx_next = idx + pwm_seq_pkg::CNT_W'(wps);
		do_launch = |launch;
		target = do_launch ? ~launch[0] : ~seq_sel; // see RULE_09
		do_stop = stop_pending && period_end && gen_running;
		// step mode advances only on the task, ignoring refresh
		hold_done = step_on_command_mode ? step_pending : hold_cnt == '0; // see RULE_17
		do_switch = state == pwm_seq_pkg::ST_GAP && gap_cnt == '0;
		// without a ready buffer the old compare value simply runs again
		do_apply = buf_ready && !do_stop && ((state == pwm_seq_pkg::ST_FETCH
			&& (!gen_running || period_end)) || (state == pwm_seq_pkg::ST_PLAY
			&& period_end && !play_last && hold_done)); // see RULE_16
		play_expire = state == pwm_seq_pkg::ST_PLAY && period_end && play_last && hold_done;
	end

	// register writes; mode, decoder and loop act at once
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int n = 0; n < 2; n++) begin
				seq_cfg[n] <= '0;
			end
			load_mode <= pwm_seq_pkg::LOAD_COMMON;
			step_on_command_mode <= 1'b0;
			chain_repeat_count <= '0;
			counter_wrap_value <= '0;
			mask <= '0;
		end else if (clk_en && reg_write) begin
			if (reg_addr == pwm_seq_pkg::OFS_CONFIG) begin
				load_mode <= pwm_seq_pkg::load_mode_type'(reg_wdata[pwm_seq_pkg::CFG_LOAD_LSB +: 2]);
				step_on_command_mode <= reg_wdata[pwm_seq_pkg::CFG_STEP_BIT]; // see RULE_06
			end
			if (reg_addr == pwm_seq_pkg::OFS_CHAIN) begin
				chain_repeat_count <= reg_wdata[pwm_seq_pkg::LOOP_W-1:0];
			end
			if (reg_addr == pwm_seq_pkg::OFS_WRAP) begin
				counter_wrap_value <= reg_wdata[pwm_seq_pkg::TOP_W-1:0];
			end
			if (reg_addr == pwm_seq_pkg::OFS_MASK) begin
				mask <= reg_wdata[pwm_seq_pkg::EV_W-1:0];
			end
			for (int n = 0; n < 2; n++) begin
				if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_PTR)) begin
					seq_cfg[n].ptr <= reg_wdata;
				end
				if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_COUNT)) begin
					seq_cfg[n].count <= reg_wdata[pwm_seq_pkg::CNT_W-1:0];
				end
				if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_REFRESH)) begin
					seq_cfg[n].refresh <= reg_wdata[pwm_seq_pkg::REFRESH_W-1:0];
				end
				if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_GAP)) begin
					seq_cfg[n].gap <= reg_wdata[pwm_seq_pkg::REFRESH_W-1:0];
				end
			end
		end
	end

	// read data, valid only in the cycle after the read strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
		end else if (clk_en) begin
			reg_rdata <= 32'h0;
			if (reg_read) begin
				unique case (reg_addr)
					pwm_seq_pkg::OFS_STATUS: reg_rdata <= 32'(status);
					pwm_seq_pkg::OFS_MASK: reg_rdata <= 32'(mask);
					pwm_seq_pkg::OFS_CONFIG: reg_rdata <= 32'({step_on_command_mode, load_mode});
					pwm_seq_pkg::OFS_CHAIN: reg_rdata <= 32'(chain_repeat_count);
					pwm_seq_pkg::OFS_WRAP: reg_rdata <= 32'(counter_wrap_value);
					pwm_seq_pkg::OFS_STATE: reg_rdata <= {13'h0000, seq_sel, gen_running,
						stop_pending, iter};
					default: begin
						for (int n = 0; n < 2; n++) begin
							if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_PTR)) begin
								reg_rdata <= seq_cfg[n].ptr;
							end
							if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_COUNT)) begin
								reg_rdata <= 32'(seq_cfg[n].count);
							end
							if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_REFRESH)) begin
								reg_rdata <= 32'(seq_cfg[n].refresh);
							end
							if (seq_field_hit(reg_addr, n, pwm_seq_pkg::SEQ_F_GAP)) begin
								reg_rdata <= 32'(seq_cfg[n].gap);
							end
						end
					end
				endcase
			end
		end
	end

	// playback sequencer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= pwm_seq_pkg::ST_IDLE;
			cur <= '0;
			fetch_req <= '0;
			seq_sel <= 1'b0;
			idx <= '0;
			iter <= '0;
			hold_cnt <= '0;
			gap_cnt <= '0;
			buf_ready <= 1'b0;
			fetch_last <= 1'b0;
			play_last <= 1'b0;
			stop_pending <= 1'b0;
			step_pending <= 1'b0;
			ev <= '0;
			compare_value <= '0;
			compare_load <= 1'b0;
			gen_running <= 1'b0;
		end else if (clk_en) begin
			fetch_req.go <= 1'b0;
			compare_load <= 1'b0;
			ev <= '0;
			if (task_stop && gen_running) begin
				stop_pending <= 1'b1;
			end
			// the advance task never starts generation by itself
			if (task_adv && gen_running && step_on_command_mode) begin
				step_pending <= 1'b1; // see RULE_14
			end
			if (fetch_done) begin
				buf_ready <= 1'b1;
			end
			if (do_launch || do_switch) begin
				// a stale fetch in flight is restarted by the new go
				seq_sel <= target;
				cur <= seq_cfg[target]; // see RULE_01, see RULE_03
				state <= pwm_seq_pkg::ST_FETCH;
				idx <= pwm_seq_pkg::CNT_W'(wps);
				fetch_req <= '{go: 1'b1, addr: seq_cfg[target].ptr, words: wps};
				fetch_last <= pwm_seq_pkg::CNT_W'(wps) >= seq_cfg[target].count;
				buf_ready <= 1'b0;
				step_pending <= 1'b0;
				if (do_launch) begin
					iter <= '0; // see RULE_19
					stop_pending <= 1'b0;
				end else if (seq_sel) begin
					iter <= iter + pwm_seq_pkg::LOOP_W'(1); // see RULE_19
				end
			end else if (do_stop) begin
				state <= pwm_seq_pkg::ST_IDLE;
				gen_running <= 1'b0;
				stop_pending <= 1'b0;
				step_pending <= 1'b0;
				buf_ready <= 1'b0;
				ev[pwm_seq_pkg::EV_STOPPED] <= 1'b1;
			end else if (do_apply) begin
				compare_value <= route(fetch_sample, load_mode);
				compare_load <= 1'b1;
				gen_running <= 1'b1;
				buf_ready <= 1'b0;
				step_pending <= 1'b0;
				play_last <= fetch_last;
				state <= pwm_seq_pkg::ST_PLAY;
				hold_cnt <= seq_cfg[seq_sel].refresh; // see RULE_11, see RULE_03
				cur.refresh <= seq_cfg[seq_sel].refresh;
				cur.gap <= seq_cfg[seq_sel].gap; // see RULE_03
				if (state == pwm_seq_pkg::ST_FETCH) begin
					ev[pwm_seq_pkg::EV_BEGUN0 + 32'(seq_sel)] <= 1'b1;
				end
				if (!fetch_last) begin
					// prefetch the following sample while this one plays
					fetch_req <= '{go: 1'b1, addr: cur.ptr + {16'h0000, idx, 1'b0}, words: wps};
					idx <= idx_next;
					fetch_last <= idx_next >= cur.count;
				end else begin
					ev[pwm_seq_pkg::EV_FINISHED0 + 32'(seq_sel)] <= 1'b1;
					if (chain_repeat_count == '0) begin
						state <= pwm_seq_pkg::ST_FINAL; // see RULE_18
					end else if (seq_sel && iter + pwm_seq_pkg::LOOP_W'(1) >= chain_repeat_count) begin
						// chain ends only after a pass of sequence 1
						ev[pwm_seq_pkg::EV_CHAIN_DONE] <= 1'b1; // see RULE_13, see RULE_10
						state <= pwm_seq_pkg::ST_FINAL; // see RULE_08
					end else if (!step_on_command_mode) begin
						// hold of the last sample and the gap run as one count, so the
						// next sequence is fetched a period ahead of its first apply
						state <= pwm_seq_pkg::ST_GAP;
						gap_cnt <= {1'b0, seq_cfg[seq_sel].refresh}
							+ {1'b0, seq_cfg[seq_sel].gap}; // see RULE_12
					end
				end
			end else if (play_expire) begin
				state <= pwm_seq_pkg::ST_GAP;
				gap_cnt <= step_on_command_mode ? '0 : {1'b0, cur.gap}; // see RULE_12, see RULE_17
				step_pending <= 1'b0;
			end else if (state == pwm_seq_pkg::ST_PLAY && period_end && !hold_done) begin
				if (!step_on_command_mode) begin
					hold_cnt <= hold_cnt - pwm_seq_pkg::REFRESH_W'(1); // see RULE_11
				end
			end else if (state == pwm_seq_pkg::ST_GAP && period_end) begin
				gap_cnt <= gap_cnt - (pwm_seq_pkg::REFRESH_W + 1)'(1); // see RULE_12
			end
		end
	end

	// period length: per-sample word in period_per_sample_load_mode load, else wrap register at period end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			counter_top <= '0;
		end else if (clk_en) begin
			if (load_mode == pwm_seq_pkg::PERIOD_PER_SAMPLE_LOAD_MODE) begin
				if (do_apply) begin
					counter_top <= fetch_sample[3][pwm_seq_pkg::TOP_W-1:0]; // see RULE_04
				end
			end else if (period_end || !gen_running) begin
				counter_top <= counter_wrap_value; // see RULE_05
			end
		end
	end

	// sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			status <= '0;
			irq <= 1'b0;
		end else if (clk_en) begin
			status <= (status & ~((reg_write && reg_addr == pwm_seq_pkg::OFS_STATUS)
				? reg_wdata[pwm_seq_pkg::EV_W-1:0] : '0)) | ev
				| (pwm_seq_pkg::EV_W'(period_end && gen_running) << pwm_seq_pkg::EV_PERIOD);
			irq <= |(status & mask);
		end
	end
endmodule

/* logic/sample_fetch.sv */
`timescale 1ns/1ps
module sample_fetch (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input pwm_seq_pkg::fetch_req_type req,
	input wire logic ram_ack,
	input wire logic [pwm_seq_pkg::CMP_W-1:0] ram_rdata,
	output logic ram_req,
	output logic [31:0] ram_addr,
	output pwm_seq_pkg::sample_type sample,
	output logic done
);
	logic [2:0] left;
	logic [1:0] slot;

	// one halfword per acknowledged read; a new go restarts the burst at once
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ram_req <= 1'b0;
			ram_addr <= 32'h0;
			left <= 3'h0;
			slot <= 2'h0;
			done <= 1'b0;
			sample <= '0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (req.go) begin
				ram_req <= 1'b1;
				ram_addr <= req.addr;
				left <= req.words;
				slot <= 2'h0;
			end else if (ram_req && ram_ack) begin
				sample[slot] <= ram_rdata;
				slot <= slot + 2'h1;
				ram_addr <= ram_addr + pwm_seq_pkg::HALFWORD_BYTES;
				left <= left - 3'h1;
				if (left == 3'h1) begin
					ram_req <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
